// *** logic/mesu_defines.vh ***
// Constants for the mask extract and shift unit
`ifndef MESU_DEFINES_VH
`define MESU_DEFINES_VH
`define MESU_WORD_W      48
`define MESU_CNT_W       6
`define MESU_OP_W        4
`define MESU_OP_NOP      4'h0
`define MESU_OP_LOAD_OPR 4'h1
`define MESU_OP_LOAD_ACC 4'h2
`define MESU_OP_ADD      4'h3
`define MESU_OP_SUB      4'h4
`define MESU_OP_INS      4'h5
`define MESU_OP_INS_ST   4'h6
`define MESU_OP_XOR_ST   4'h7
`define MESU_OP_OR_ST    4'h8
`define MESU_OP_SHIFT    4'h9
`define MESU_OP_LOAD_A   4'hA
`define MESU_OP_LOAD_Q   4'hB
`define MESU_OP_LOAD_D   4'hC
`define MESU_SH_ORD      2'h0
`define MESU_SH_NUM      2'h1
`define MESU_SH_CIRC     2'h2
`define MESU_RG_A        2'h0
`define MESU_RG_Q        2'h1
`define MESU_RG_D        2'h2
`define MESU_RG_AQ       2'h3
`define MESU_SPACE_CHAR  6'h30
`define MESU_ZERO_WORD   48'h0000_0000_0000
`endif

// *** logic/mesu_unit.v ***
// Mask extract, logical store and shift datapath
// Notes on behaviour
// - Every extract first reads the memory word into the internal mem_word register.
// - Fetched bits survive where mask bit is one, else become zero.
// - Extracted word may be added, subtracted, inserted or moved to accumulator.
// - Six extract variants: load operand, load acc, add, subtract, insert, insert-store.
// - Carry-less add sums accumulator and memory bitwise, writes result to memory.
// - OR-store puts OR of operand and memory into both operand and memory.
// - Ordinary, numerical and circular shifts, either direction, on arithmetic registers.
// - Shift moves selected register left or right by instruction count.
// - Numerical shift keeps sign; right shift replicates sign into vacated bits.
// - Characters are six-bit fields; space code is binary 110000.
// - Masking is bitwise AND of mask and memory word, sources unchanged.
// - Carry-less add keeps accumulator, result goes via operand register.
`include "mesu_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module mesu_unit (
   input  wire                       i_clock,
   input  wire                       i_rst,
   input  wire                       i_start,
   input  wire [`MESU_OP_W-1:0]      i_op,
   input  wire [1:0]                 i_shift_mode,
   input  wire [1:0]                 i_shift_reg,
   input  wire                       i_shift_left,
   input  wire [`MESU_CNT_W-1:0]     i_shift_count,
   input  wire [`MESU_WORD_W-1:0]    i_load_word,
   input  wire [`MESU_WORD_W-1:0]    i_mem_rdata,
   input  wire                       i_mem_rvalid,
   output reg                        o_mem_read,
   output reg                        o_mem_write,
   output reg  [`MESU_WORD_W-1:0]    o_mem_wdata,
   output reg                        o_busy,
   output reg                        o_done,
   output reg  [`MESU_WORD_W-1:0]    o_acc,
   output reg  [`MESU_WORD_W-1:0]    o_mask,
   output reg  [`MESU_WORD_W-1:0]    o_opr,
   output reg                        o_acc_zero,
   output reg  [5:0]                 o_space_char
);
   localparam [1:0] ST_IDLE  = 2'h0;
   localparam [1:0] ST_FETCH = 2'h1;
   localparam [1:0] ST_EXEC  = 2'h2;
   localparam [1:0] ST_SHIFT = 2'h3;
   localparam       W        = `MESU_WORD_W;

   reg [1:0]                 state;
   reg [`MESU_OP_W-1:0]      op;
   reg [1:0]                 sh_mode;
   reg [1:0]                 sh_reg;
   reg                       sh_left;
   reg [`MESU_CNT_W-1:0]     sh_left_cnt;
   reg [`MESU_WORD_W-1:0]    mem_word;
   reg [`MESU_WORD_W-1:0]    ext;
   reg [`MESU_WORD_W-1:0]    ins_word;
   reg [`MESU_WORD_W-1:0]    sum_word;
   reg [`MESU_WORD_W-1:0]    or_word;
   reg [2*`MESU_WORD_W-1:0]  pair;

   // One-position shift; the leftmost bit W-1 is the sign
   function [W-1:0] mesu_shift1;
      input [W-1:0] v;
      input [1:0]   mode;
      input         left;
      begin
         if (left) begin
            if (mode == `MESU_SH_CIRC)
               mesu_shift1 = {v[W-2:0], v[W-1]};
            else if (mode == `MESU_SH_NUM)
               mesu_shift1 = {v[W-1], v[W-3:0], 1'b0};
            else
               mesu_shift1 = {v[W-2:0], 1'b0};
         end else begin
            if (mode == `MESU_SH_CIRC)
               mesu_shift1 = {v[0], v[W-1:1]};
            else if (mode == `MESU_SH_NUM)
               mesu_shift1 = {v[W-1], v[W-1:1]};
            else
               mesu_shift1 = {1'b0, v[W-1:1]};
         end
      end
   endfunction

   // Masking is a pure AND; neither the mask nor the memory word is altered
   function [W-1:0] mesu_extract;
      input [W-1:0] mask;
      input [W-1:0] word;
      begin
         mesu_extract = mask & word;
      end
   endfunction

   // Insert keeps the accumulator bits that lie outside the mask
   function [W-1:0] mesu_insert;
      input [W-1:0] acc;
      input [W-1:0] mask;
      input [W-1:0] part;
      begin
         mesu_insert = (acc & ~mask) | part;
      end
   endfunction

   // Bitwise sum with every carry dropped
   function [W-1:0] mesu_carryless;
      input [W-1:0] a;
      input [W-1:0] b;
      begin
         mesu_carryless = a ^ b;
      end
   endfunction

   // A one in either word gives a one in the merged word
   function [W-1:0] mesu_or_merge;
      input [W-1:0] a;
      input [W-1:0] b;
      begin
         mesu_or_merge = a | b;
      end
   endfunction

   // All candidate results are formed in parallel; the latched op decides which lands
   always @* begin
      ext      = mesu_extract(o_mask, mem_word);
      ins_word = mesu_insert(o_acc, o_mask, ext);
      sum_word = mesu_carryless(o_acc, mem_word);
      or_word  = mesu_or_merge(o_opr, mem_word);
   end

   // Double-length shift of accumulator and mask register as one pair
   always @* begin
      pair = {o_acc, o_mask};
      if (sh_left) begin
         if (sh_mode == `MESU_SH_CIRC)
            pair = {o_acc[W-2:0], o_mask, o_acc[W-1]};
         else if (sh_mode == `MESU_SH_NUM)
            pair = {o_acc[W-1], o_acc[W-3:0], o_mask, 1'b0};
         else
            pair = {o_acc[W-2:0], o_mask, 1'b0};
      end else begin
         if (sh_mode == `MESU_SH_CIRC)
            pair = {o_mask[0], o_acc, o_mask[W-1:1]};
         else if (sh_mode == `MESU_SH_NUM)
            pair = {o_acc[W-1], o_acc, o_mask[W-1:1]};
         else
            pair = {1'b0, o_acc, o_mask[W-1:1]};
      end
   end

   always @(posedge i_clock) begin
      if (i_rst) begin
         state        <= ST_IDLE;
         op           <= `MESU_OP_NOP;
         sh_mode      <= `MESU_SH_ORD;
         sh_reg       <= `MESU_RG_A;
         sh_left      <= 1'b0;
         sh_left_cnt  <= {`MESU_CNT_W{1'b0}};
         mem_word     <= `MESU_ZERO_WORD;
         o_mem_read   <= 1'b0;
         o_mem_write  <= 1'b0;
         o_mem_wdata  <= `MESU_ZERO_WORD;
         o_busy       <= 1'b0;
         o_done       <= 1'b0;
         o_acc        <= `MESU_ZERO_WORD;
         o_mask       <= `MESU_ZERO_WORD;
         o_opr        <= `MESU_ZERO_WORD;
         o_acc_zero   <= 1'b1;
         o_space_char <= `MESU_SPACE_CHAR;
      end else begin
         o_done      <= 1'b0;
         o_mem_write <= 1'b0;
         o_mem_read  <= 1'b0;
         // Zero flag lags the accumulator by one cycle
         o_acc_zero  <= (o_acc == `MESU_ZERO_WORD);
         case (state)
            ST_IDLE: begin
               if (i_start) begin
                  op      <= i_op;
                  sh_mode <= i_shift_mode;
                  sh_reg  <= i_shift_reg;
                  sh_left <= i_shift_left;
                  sh_left_cnt <= i_shift_count;
                  o_busy  <= 1'b1;
                  case (i_op)
                     `MESU_OP_LOAD_A: begin
                        o_acc  <= i_load_word;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                     end
                     `MESU_OP_LOAD_Q: begin
                        o_mask <= i_load_word;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                     end
                     `MESU_OP_LOAD_D: begin
                        o_opr  <= i_load_word;
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                     end
                     `MESU_OP_SHIFT: begin
                        state <= ST_SHIFT;
                     end
                     `MESU_OP_NOP: begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                     end
                     `MESU_OP_LOAD_OPR, `MESU_OP_LOAD_ACC, `MESU_OP_ADD,
                     `MESU_OP_SUB, `MESU_OP_INS, `MESU_OP_INS_ST,
                     `MESU_OP_XOR_ST, `MESU_OP_OR_ST: begin
                        o_mem_read <= 1'b1;
                        state      <= ST_FETCH;
                     end
                     // Unused codes finish like a nop instead of reading memory for nothing
                     default: begin
                        o_busy <= 1'b0;
                        o_done <= 1'b1;
                     end
                  endcase
               end
            end
            // No time limit here: every read is assumed to be answered
            ST_FETCH: begin
               if (i_mem_rvalid) begin
                  mem_word <= i_mem_rdata;
                  state    <= ST_EXEC;
               end
            end
            ST_EXEC: begin
               state  <= ST_IDLE;
               o_busy <= 1'b0;
               o_done <= 1'b1;
               case (op)
                  // The masked word lands in the operand register for every extract except insert-store
                  `MESU_OP_LOAD_OPR: begin
                     o_opr <= ext;
                  end
                  `MESU_OP_LOAD_ACC: begin
                     o_opr <= ext;
                     o_acc <= ext;
                  end
                  `MESU_OP_ADD: begin
                     o_opr <= ext;
                     o_acc <= o_acc + ext;
                  end
                  `MESU_OP_SUB: begin
                     o_opr <= ext;
                     o_acc <= o_acc - ext;
                  end
                  // Insert keeps accumulator bits outside the mask
                  `MESU_OP_INS: begin
                     o_opr <= ext;
                     o_acc <= ins_word;
                  end
                  `MESU_OP_INS_ST: begin
                     o_opr       <= ins_word;
                     o_acc       <= ins_word;
                     o_mem_wdata <= ins_word;
                     o_mem_write <= 1'b1;
                  end
                  // Accumulator deliberately untouched by the carry-less sum
                  `MESU_OP_XOR_ST: begin
                     o_opr       <= sum_word;
                     o_mem_wdata <= sum_word;
                     o_mem_write <= 1'b1;
                  end
                  `MESU_OP_OR_ST: begin
                     o_opr       <= or_word;
                     o_mem_wdata <= or_word;
                     o_mem_write <= 1'b1;
                  end
                  default: begin
                     o_opr <= o_opr;
                  end
               endcase
            end
            ST_SHIFT: begin
               // One position per cycle keeps the shifter small; count 0 ends at once
               if (sh_left_cnt == {`MESU_CNT_W{1'b0}}) begin
                  state  <= ST_IDLE;
                  o_busy <= 1'b0;
                  o_done <= 1'b1;
               end else begin
                  sh_left_cnt <= sh_left_cnt - {{(`MESU_CNT_W-1){1'b0}}, 1'b1};
                  case (sh_reg)
                     `MESU_RG_A: o_acc  <= mesu_shift1(o_acc, sh_mode, sh_left);
                     `MESU_RG_Q: o_mask <= mesu_shift1(o_mask, sh_mode, sh_left);
                     `MESU_RG_D: o_opr  <= mesu_shift1(o_opr, sh_mode, sh_left);
                     default: begin
                        o_acc  <= pair[2*W-1:W];
                        o_mask <= pair[W-1:0];
                     end
                  endcase
               end
            end
            default: begin
               state  <= ST_IDLE;
               o_busy <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// *** dv/mesu_unit_properties.sv ***
// Assertion checker for the mask extract and shift unit
`timescale 1ns/10ps
`default_nettype none
`include "mesu_defines.vh"
module mesu_props (
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_start,
   input wire logic [3:0]  i_op,
   input wire logic [47:0] i_mem_rdata,
   input wire logic        i_mem_rvalid,
   input wire logic        o_mem_read,
   input wire logic        o_mem_write,
   input wire logic [47:0] o_mem_wdata,
   input wire logic        o_busy,
   input wire logic        o_done,
   input wire logic [47:0] o_acc,
   input wire logic [47:0] o_mask,
   input wire logic [47:0] o_opr,
   input wire logic [5:0]  o_space_char
);
   logic [3:0] op_q = 4'h0;
   wire        got = i_mem_rvalid && o_busy;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   // The answer arrives cycles after the command, so keep the taken code
   always @(posedge i_clock) begin
      if (i_start && !o_busy) op_q <= i_op;
   end
   read_first_a: assert property (i_start && !o_busy && (i_op inside {[4'h1:4'h8]})
      |=> o_mem_read && o_busy && !o_done) else $error("memory word not requested first");
   // Data is taken at the valid edge and the result lands one edge later
   mask_and_a: assert property (got && op_q == `MESU_OP_LOAD_OPR
      |=> ##1 o_opr == ($past(o_mask, 2) & $past(i_mem_rdata, 2)) && $stable(o_mask))
      else $error("bad mask");
   load_acc_a: assert property (got && op_q == `MESU_OP_LOAD_ACC
      |=> ##1 o_acc == ($past(o_mask, 2) & $past(i_mem_rdata, 2)))
      else $error("bad masked load");
   add_ext_a: assert property (got && op_q == `MESU_OP_ADD
      |=> ##1 o_acc == $past(o_acc, 2) + ($past(o_mask, 2) & $past(i_mem_rdata, 2)))
      else $error("bad add");
   sub_ext_a: assert property (got && op_q == `MESU_OP_SUB
      |=> ##1 o_acc == $past(o_acc, 2) - ($past(o_mask, 2) & $past(i_mem_rdata, 2)))
      else $error("bad sub");
   mask_insert_a: assert property (got && op_q == `MESU_OP_INS
      |=> ##1 o_acc == (($past(o_acc, 2) & ~$past(o_mask, 2))
      | ($past(o_mask, 2) & $past(i_mem_rdata, 2)))) else $error("bad insert");
   insert_store_a: assert property (got && op_q == `MESU_OP_INS_ST
      |=> ##1 o_mem_write && o_acc == o_mem_wdata && o_opr == o_mem_wdata
      && o_mem_wdata == (($past(o_acc, 2) & ~$past(o_mask, 2))
      | ($past(o_mask, 2) & $past(i_mem_rdata, 2)))) else $error("bad insert store");
   xor_store_a: assert property (got && op_q == `MESU_OP_XOR_ST |=> ##1 o_mem_write &&
      o_mem_wdata == ($past(o_acc, 2) ^ $past(i_mem_rdata, 2)) && o_opr == o_mem_wdata
      && $stable(o_acc)) else $error("bad carryless store");
   or_store_a: assert property (got && op_q == `MESU_OP_OR_ST |=> ##1 o_mem_write &&
      o_mem_wdata == ($past(o_opr, 2) | $past(i_mem_rdata, 2)) && o_opr == o_mem_wdata)
      else $error("bad or store");
   space_code_a: assert property (o_space_char == 6'h30) else $error("bad space code");
   cover property (got && op_q == `MESU_OP_INS_ST);
   cover property (o_done && op_q == `MESU_OP_SHIFT);
   cover property (o_mem_write && op_q == `MESU_OP_OR_ST);
endmodule
bind mesu_unit mesu_props chk (.i_clock, .i_rst, .i_start, .i_op, .i_mem_rdata, .i_mem_rvalid,
   .o_mem_read, .o_mem_write, .o_mem_wdata, .o_busy, .o_done, .o_acc, .o_mask, .o_opr,
   .o_space_char);
`default_nettype wire

// *** dv/mesu_mem_model.sv ***
// Behavioural main memory answering the unit's read and write pulses
`timescale 1ns/10ps
`default_nettype none
module mesu_mem_model (
   input  wire logic        i_clock,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [47:0] i_wdata,
   input  wire logic [3:0]  i_lat,
   output var  logic        o_rvalid,
   output var  logic [47:0] o_rdata
);
   logic [47:0] word = 48'h0000_0000_0000;
   logic [3:0]  cnt = 4'h0;
   initial o_rvalid = 1'b0;
   initial o_rdata = 48'h0000_0000_0000;
   // Data toggles outside a reply so a stale word never passes for an answer
   always @(posedge i_clock) begin
      o_rvalid <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_read) cnt <= i_lat;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
      if (cnt == 4'h1) begin
         o_rvalid <= 1'b1;
         o_rdata <= word;
      end
      if (i_write) word <= i_wdata;
   end
endmodule
`default_nettype wire

// *** dv/mesu_unit_tb.sv ***
// Self-checking bench for the mask extract and shift unit
`timescale 1ns/10ps
`default_nettype none
`include "mesu_defines.vh"
module mesu_unit_tb;
   logic        i_clock = 1'b0, i_rst = 1'b1, i_start = 1'b0, i_shift_left = 1'b0;
   logic [3:0]  i_op = 4'h0, lat = 4'h1;
   logic [1:0]  i_shift_mode = 2'h0, i_shift_reg = 2'h0;
   logic [5:0]  i_shift_count = 6'h00, o_space_char;
   logic [47:0] i_load_word = 48'h0000_0000_0000, i_mem_rdata, o_mem_wdata, o_acc, o_mask, o_opr;
   logic        i_mem_rvalid, o_mem_read, o_mem_write, o_busy, o_done, o_acc_zero;
   int          errors = 0, total_checks = 0;
   mesu_unit dut (.i_clock, .i_rst, .i_start, .i_op, .i_shift_mode, .i_shift_reg, .i_shift_left,
      .i_shift_count, .i_load_word, .i_mem_rdata, .i_mem_rvalid, .o_mem_read, .o_mem_write,
      .o_mem_wdata, .o_busy, .o_done, .o_acc, .o_mask, .o_opr, .o_acc_zero, .o_space_char);
   mesu_mem_model mem (.i_clock, .i_read(o_mem_read), .i_write(o_mem_write), .i_wdata(o_mem_wdata),
      .i_lat(lat), .o_rvalid(i_mem_rvalid), .o_rdata(i_mem_rdata));
   initial forever #5 i_clock = ~i_clock;
   task summarize;
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One extra cycle after done lets the memory take the write pulse
   task cmd(input logic [3:0] op, input logic [47:0] w);
      int k;
      @(negedge i_clock);
      i_op = op;
      i_load_word = w;
      i_start = 1'b1;
      @(negedge i_clock);
      i_start = 1'b0;
      k = 0;
      while (o_done !== 1'b1 && k < 100) begin
         @(negedge i_clock);
         k++;
      end
      chk("done", 48'h0000_0000_0001, {47'h0, o_done});
      @(negedge i_clock);
   endtask
   task sh(input logic [1:0] md, input logic [1:0] rg, input logic lf, input logic [5:0] n);
      i_shift_mode = md;
      i_shift_reg = rg;
      i_shift_left = lf;
      i_shift_count = n;
      cmd(`MESU_OP_SHIFT, 48'h0000_0000_0000);
   endtask
   task t_extract;
      logic [47:0] a, m, d, x, e;
      a = 48'h0123_4567_89AB;
      m = 48'hFF00_F0F0_000F;
      d = 48'hA5A5_5A5A_C3C3;
      x = m & d;
      cmd(`MESU_OP_LOAD_Q, m);
      for (int op = 1; op <= 6; op++) begin
         lat = op[3:0];
         mem.word = d;
         cmd(`MESU_OP_LOAD_A, a);
         cmd(op[3:0], 48'h0000_0000_0000);
         e = (op == 2) ? x : (op == 3) ? a + x : (op == 4) ? a - x : (op >= 5) ? (a & ~m) | x : a;
         chk("accumulator", e, o_acc);
         chk("operand", (op == 6) ? e : x, o_opr);
         chk("mask", m, o_mask);
         chk("memory", (op == 6) ? e : d, mem.word);
      end
      $display("test extract done");
   endtask
   task t_logic;
      logic [47:0] a, d;
      a = 48'hF0F0_0000_FFFF;
      d = 48'h0FF0_1234_00FF;
      cmd(`MESU_OP_LOAD_A, a);
      mem.word = d;
      cmd(`MESU_OP_XOR_ST, 48'h0000_0000_0000);
      chk("memory", a ^ d, mem.word);
      chk("accumulator", a, o_acc);
      chk("operand", a ^ d, o_opr);
      cmd(`MESU_OP_LOAD_D, 48'h8000_0000_0F0F);
      cmd(`MESU_OP_OR_ST, 48'h0000_0000_0000);
      chk("memory", a ^ d | 48'h8000_0000_0F0F, mem.word);
      chk("operand", a ^ d | 48'h8000_0000_0F0F, o_opr);
      $display("test logic done");
   endtask
   task t_shift;
      cmd(`MESU_OP_LOAD_Q, 48'hFC00_0000_0000);
      sh(`MESU_SH_NUM, `MESU_RG_Q, 1'b0, 6'h06);
      chk("mask", 48'hFFF0_0000_0000, o_mask);
      sh(`MESU_SH_ORD, `MESU_RG_Q, 1'b1, 6'h06);
      chk("mask", 48'hFC00_0000_0000, o_mask);
      cmd(`MESU_OP_LOAD_A, 48'h8000_0000_0001);
      sh(`MESU_SH_CIRC, `MESU_RG_A, 1'b1, 6'h04);
      chk("accumulator", 48'h0000_0000_0018, o_acc);
      cmd(`MESU_OP_LOAD_D, 48'h8000_0000_0000);
      sh(`MESU_SH_ORD, `MESU_RG_D, 1'b0, 6'h03);
      chk("operand", 48'h1000_0000_0000, o_opr);
      chk("space", 48'h0000_0000_0030, {42'h0, o_space_char});
      $display("test shift done");
   endtask
   // Double-length pair, numerical left, circular right, nop and the zero flag
   task t_pair;
      cmd(`MESU_OP_LOAD_A, 48'h0000_0000_0001);
      cmd(`MESU_OP_LOAD_Q, 48'h8000_0000_0000);
      sh(`MESU_SH_ORD, `MESU_RG_AQ, 1'b1, 6'h01);
      chk("accumulator", 48'h0000_0000_0003, o_acc);
      chk("mask", 48'h0000_0000_0000, o_mask);
      chk("acc zero", 48'h0000_0000_0000, {47'h0, o_acc_zero});
      cmd(`MESU_OP_LOAD_A, 48'h8000_0000_0003);
      sh(`MESU_SH_NUM, `MESU_RG_A, 1'b1, 6'h01);
      chk("accumulator", 48'h8000_0000_0006, o_acc);
      sh(`MESU_SH_CIRC, `MESU_RG_A, 1'b0, 6'h02);
      chk("accumulator", 48'hA000_0000_0001, o_acc);
      cmd(`MESU_OP_NOP, 48'h0000_0000_0000);
      chk("accumulator", 48'hA000_0000_0001, o_acc);
      cmd(`MESU_OP_LOAD_A, 48'h0000_0000_0000);
      chk("acc zero", 48'h0000_0000_0001, {47'h0, o_acc_zero});
      $display("test pair done");
   endtask
   initial begin
      repeat (4) @(negedge i_clock);
      i_rst = 1'b0;
      t_extract;
      t_logic;
      t_shift;
      t_pair;
      summarize;
   end
   initial begin
      #50000;
      errors++;
      $display("unexpected watchdog expected finish seen hang");
      summarize;
   end
endmodule
`default_nettype wire
